// File: hw/pinsel_pkg.sv
// Constants, register map and types for the pin function select block
package pinsel_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int PADDR_W = 8; // APB address width
	localparam int PDATA_W = 32; // APB data width
	localparam int REG_W = 8; // Width of each control register

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CFG0 = 8'h00; // io_config_0
	localparam logic [7:0] IDX_CFG1 = 8'h01; // io_config_1
	localparam logic [7:0] IDX_CFG2 = 8'h02; // io_config_2
	localparam logic [7:0] IDX_CFG3 = 8'h03; // io_config_3
	localparam logic [7:0] IDX_WSEL = 8'h04; // window_select
	localparam logic [7:0] IDX_STAT = 8'h05; // Takeover status, read only
	localparam logic [7:0] IDX_PORT1 = 8'h0F; // Port 1 latch, page 0
	localparam logic [7:0] IDX_PORT2 = 8'h10; // Port 2 latch, page 0

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int B_FEI1_EN = 2; // io_config_0: pin 25 event input
	localparam int B_FEI2_EN = 4; // io_config_0: pin 26 event input
	localparam int B_FEI3_EN = 6; // io_config_0: pin 27 event input
	localparam int B_C2CLK_EN = 7; // io_config_0: counter 2 ext clock
	localparam int B_TOUT4_EN = 4; // io_config_1: pin 26 timed output
	localparam int B_TOUT5_EN = 6; // io_config_1: pin 27 timed output
	localparam int B_C2DIR_EN = 1; // io_config_2: pin 33 direction input
	localparam int B_C2CLK_INH = 0; // io_config_3: ext clock inhibit
	localparam int B_TAKEOVER = 7; // window_select: takeover pins
	localparam int B_P1_LO = 5; // Lowest port 1 bit on these pins
	localparam int B_P2_B6 = 6; // Port 2 bit on pin 33

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CFG = 8'h00; // Config registers
	localparam logic [7:0] RST_PORT = 8'hFF; // Quasi port latches float high

	// ----------------------------------------------------------------
	// Synchroniser lanes
	// ----------------------------------------------------------------
	localparam int N_SYNC = 7; // Pins sampled from outside
	localparam int S_P25 = 0;
	localparam int S_P26 = 1;
	localparam int S_P27 = 2;
	localparam int S_P30 = 3;
	localparam int S_P31 = 4;
	localparam int S_P32 = 5;
	localparam int S_P33 = 6;

	// Takeover handshake states
	typedef enum logic [1:0] {
		TK_IDLE,
		TK_RELEASE,
		TK_GRANTED
	} takeover_t;

endpackage

// File: hw/sync2.sv
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1 // Number of lanes
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Levels in and out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta; // First stage, read only by the second

	// Two stages; reset parks both low
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // sync2
`default_nettype wire

// File: hw/pin_function_select.sv
// Pin 25..33 function select and bus takeover handshake
//
// Summary of operation
// R01: io_config_0 bit 2 routes pin 25 events
// R02: Pin 25 clocks counter 2 when enabled
// R03: io_config_1 bit 4 drives timed output 4
// R04: Pin 26 output and input work together
// R05: io_config_0 bit 4 routes pin 26 events
// R06: io_config_1 bit 6 drives timed output 5
// R07: io_config_0 bit 6 routes pin 27 events
// R08: Pins 28, 29 always timed outputs 0, 1
// R09: window_select bit 7 picks takeover pins
// R10: Port 1 bits quasi, at index 0Fh
// R11: Port 2 bit 6 quasi, at index 10h
// R12: Bus request follows pending external cycles
// R13: Bus request only after grant asserted
// R14: Bus request holds until request released
// R15: Release bus, then assert the grant
// R16: Far master asserts takeover request low
// R17: Direction one counts down, zero up
// R18: Direction pin used only when enabled
// R19: Far master waits for grant, holds request
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pin_function_select
	import pinsel_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [PADDR_W-1:0] PADDR,
	input wire logic [PDATA_W-1:0] PWDATA,
	output logic [PDATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Pins 25 to 27
	input wire logic PIN25_IN,
	input wire logic PIN26_IN,
	output logic PIN26_OUT,
	output logic PIN26_OE,
	input wire logic PIN27_IN,
	output logic PIN27_OUT,
	output logic PIN27_OE,
	// Pins 28 and 29, dedicated outputs
	output logic PIN28_OUT,
	output logic PIN29_OUT,
	// Pins 30 to 33
	input wire logic PIN30_IN,
	output logic PIN30_OUT,
	output logic PIN30_OE,
	input wire logic PIN31_IN,
	output logic PIN31_OUT,
	output logic PIN31_OE,
	input wire logic PIN32_IN,
	output logic PIN32_OUT,
	output logic PIN32_OE,
	input wire logic PIN33_IN,
	output logic PIN33_OUT,
	output logic PIN33_OE,
	// Timed output unit channels
	input wire logic TIMED_OUTPUT_CH0,
	input wire logic TIMED_OUTPUT_CH1,
	input wire logic TIMED_OUTPUT_CH4,
	input wire logic TIMED_OUTPUT_CH5,
	// Fast event input unit channels
	output logic FAST_EVENT_INPUT_CH1,
	output logic FAST_EVENT_INPUT_CH2,
	output logic FAST_EVENT_INPUT_CH3,
	output logic FAST_EVENT_INPUT_EN1,
	output logic FAST_EVENT_INPUT_EN2,
	output logic FAST_EVENT_INPUT_EN3,
	// Counter 2
	output logic COUNTER2_EXT_CLOCK,
	output logic COUNTER2_EXT_CLOCK_EN,
	output logic COUNTER2_DOWN,
	// Internal bus controller
	input wire logic MEM_CYCLE_PENDING,
	input wire logic BUS_IDLE,
	output logic BUS_RELEASE
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [REG_W-1:0] io_config_0; // Event inputs, ext clock
	logic [REG_W-1:0] io_config_1; // Timed output enables
	logic [REG_W-1:0] io_config_2; // Direction input enable
	logic [REG_W-1:0] io_config_3; // Ext clock inhibit
	logic [REG_W-1:0] window_select; // Takeover select in bit 7
	logic [REG_W-1:0] port_one; // Port 1 output latch
	logic [REG_W-1:0] port_two; // Port 2 output latch
	logic [N_SYNC-1:0] pin_raw; // Pin levels before sync
	logic [N_SYNC-1:0] pin_s; // Synchronised pin levels
	takeover_t tk_state; // Takeover handshake state
	takeover_t next_tk_state; // Its next value
	logic grant; // Takeover grant, active high
	logic bus_req; // Bus request, active high
	logic hold_req; // Takeover request seen, active high
	logic takeover_mode; // Pins 30..32 in takeover use
	logic wr_en; // APB write strobe
	logic rd_setup; // APB read in its setup cycle
	logic hit; // Address decodes to a register
	logic [REG_W-1:0] rd_val; // Decoded read value
	logic [PADDR_W-1:0] byte_addr; // Incoming address

	// ----------------------------------------------------------------
	// Pin input synchronisers
	// ----------------------------------------------------------------
	assign pin_raw = {PIN33_IN, PIN32_IN, PIN31_IN, PIN30_IN,
		PIN27_IN, PIN26_IN, PIN25_IN};

	sync2 #(
		.WIDTH(N_SYNC)
	) u_sync (
		.clk(CLK_SYS),
		.srst(SRST),
		.d(pin_raw),
		.q(pin_s)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign byte_addr = PADDR;
	assign wr_en = PSEL & PENABLE & PWRITE & hit;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
	// Zero wait states; read data is staged in setup
	assign PREADY = 1'b1;
	// Unmapped access flags an error in the access cycle
	assign PSLVERR = PSEL & PENABLE & ~hit;
	assign takeover_mode = window_select[B_TAKEOVER];

	// Address decode and read mux
	always_comb begin
		hit = 1'b1;
		rd_val = '0;
		unique case (byte_addr)
			8'(IDX_CFG0 * 4): rd_val = io_config_0;
			8'(IDX_CFG1 * 4): rd_val = io_config_1;
			8'(IDX_CFG2 * 4): rd_val = io_config_2;
			8'(IDX_CFG3 * 4): rd_val = io_config_3;
			8'(IDX_WSEL * 4): rd_val = window_select;
			8'(IDX_STAT * 4): rd_val = {4'h0, BUS_RELEASE, hold_req, bus_req, grant}; // Handshake state
			8'(IDX_PORT1 * 4): begin
				// Quasi pins read back their level [R10]
				rd_val = port_one;
				if (!takeover_mode) begin
					rd_val[7:B_P1_LO] = pin_s[S_P32:S_P30];
				end
			end
			8'(IDX_PORT2 * 4): begin
				// Pin 33 level when in port use [R11]
				rd_val = port_two;
				if (!io_config_2[B_C2DIR_EN]) begin
					rd_val[B_P2_B6] = pin_s[S_P33];
				end
			end
			default: hit = 1'b0;
		endcase
	end

	// Read data staged in setup, valid during access
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			PRDATA <= '0;
		end else if (rd_setup) begin
			PRDATA <= {24'h000000, rd_val};
		end
	end

	// Configuration register writes
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			io_config_0 <= RST_CFG;
			io_config_1 <= RST_CFG;
			io_config_2 <= RST_CFG;
			io_config_3 <= RST_CFG;
			window_select <= RST_CFG;
		end else if (wr_en) begin
			unique case (byte_addr)
				8'(IDX_CFG0 * 4): io_config_0 <= PWDATA[REG_W-1:0];
				8'(IDX_CFG1 * 4): io_config_1 <= PWDATA[REG_W-1:0];
				8'(IDX_CFG2 * 4): io_config_2 <= PWDATA[REG_W-1:0];
				8'(IDX_CFG3 * 4): io_config_3 <= PWDATA[REG_W-1:0];
				8'(IDX_WSEL * 4): window_select <= PWDATA[REG_W-1:0];
				default: ; // Ports handled elsewhere, status writes ignored
			endcase
		end
	end

	// Port latches at page 0 locations [R10] [R11]
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			port_one <= RST_PORT;
			port_two <= RST_PORT;
		end else if (wr_en) begin
			if (byte_addr == 8'(IDX_PORT1 * 4)) begin
				port_one <= PWDATA[REG_W-1:0];
			end
			if (byte_addr == 8'(IDX_PORT2 * 4)) begin
				port_two <= PWDATA[REG_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Event inputs and counter 2
	// ----------------------------------------------------------------
	// Event channel routing and counter 2 controls
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			FAST_EVENT_INPUT_EN1 <= 1'b0;
			FAST_EVENT_INPUT_EN2 <= 1'b0;
			FAST_EVENT_INPUT_EN3 <= 1'b0;
			FAST_EVENT_INPUT_CH1 <= 1'b0;
			FAST_EVENT_INPUT_CH2 <= 1'b0;
			FAST_EVENT_INPUT_CH3 <= 1'b0;
			COUNTER2_EXT_CLOCK_EN <= 1'b0;
			COUNTER2_EXT_CLOCK <= 1'b0;
			COUNTER2_DOWN <= 1'b0;
		end else begin
			// Pin 25 event channel 1 [R01]
			FAST_EVENT_INPUT_EN1 <= io_config_0[B_FEI1_EN];
			FAST_EVENT_INPUT_CH1 <= pin_s[S_P25];
			// Pin 26 sampled at the pad, so it sees its own output [R04] [R05]
			FAST_EVENT_INPUT_EN2 <= io_config_0[B_FEI2_EN];
			FAST_EVENT_INPUT_CH2 <= pin_s[S_P26];
			// Pin 27 event channel 3, monitors output 5 [R07]
			FAST_EVENT_INPUT_EN3 <= io_config_0[B_FEI3_EN];
			FAST_EVENT_INPUT_CH3 <= pin_s[S_P27];
			// External clock only with enable set and inhibit clear [R02]
			COUNTER2_EXT_CLOCK_EN <= io_config_0[B_C2CLK_EN] & ~io_config_3[B_C2CLK_INH];
			COUNTER2_EXT_CLOCK <= pin_s[S_P25];
			// Direction pin counts down on one, up otherwise [R17] [R18]
			COUNTER2_DOWN <= io_config_2[B_C2DIR_EN] & pin_s[S_P33];
		end
	end

	// ----------------------------------------------------------------
	// Bus takeover handshake
	// ----------------------------------------------------------------
	// Request pin is active low and only counts in takeover use [R16]
	assign hold_req = takeover_mode & ~pin_s[S_P32];
	// Ask the bus controller to finish and float the bus [R15]
	assign BUS_RELEASE = (tk_state != TK_IDLE);

	// Next handshake state
	always_comb begin
		next_tk_state = tk_state;
		unique case (tk_state)
			TK_IDLE: begin
				// Request seen
				if (hold_req) begin
					next_tk_state = TK_RELEASE;
				end
			end
			TK_RELEASE: begin
				// Grant only once the bus is let go [R15]
				if (!hold_req) begin
					next_tk_state = TK_IDLE;
				end else if (BUS_IDLE) begin
					next_tk_state = TK_GRANTED;
				end
			end
			TK_GRANTED: begin
				// Far master keeps request while using the bus [R19]
				if (!hold_req) begin
					next_tk_state = TK_IDLE;
				end
			end
		endcase
	end

	// Handshake state register
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			tk_state <= TK_IDLE;
		end else begin
			tk_state <= next_tk_state;
		end
	end

	// Grant and bus request flags
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			grant <= 1'b0;
			bus_req <= 1'b0;
		end else begin
			// Grant follows the bus release [R15]
			grant <= (next_tk_state == TK_GRANTED);
			// Request only once grant is already out, kept until request drops [R12] [R13] [R14]
			bus_req <= grant & (next_tk_state == TK_GRANTED) & (bus_req | MEM_CYCLE_PENDING);
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Output levels and enables, all registered
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			PIN26_OUT <= 1'b0;
			PIN26_OE <= 1'b0;
			PIN27_OUT <= 1'b0;
			PIN27_OE <= 1'b0;
			PIN28_OUT <= 1'b0;
			PIN29_OUT <= 1'b0;
			PIN30_OUT <= 1'b0;
			PIN30_OE <= 1'b0;
			PIN31_OUT <= 1'b0;
			PIN31_OE <= 1'b0;
			PIN32_OUT <= 1'b0;
			PIN32_OE <= 1'b0;
			PIN33_OUT <= 1'b0;
			PIN33_OE <= 1'b0;
		end else begin
			// Timed outputs 4 and 5 when enabled [R03] [R06]
			PIN26_OUT <= TIMED_OUTPUT_CH4;
			PIN26_OE <= io_config_1[B_TOUT4_EN];
			PIN27_OUT <= TIMED_OUTPUT_CH5;
			PIN27_OE <= io_config_1[B_TOUT5_EN];
			// Dedicated timed outputs 0 and 1 [R08]
			PIN28_OUT <= TIMED_OUTPUT_CH0;
			PIN29_OUT <= TIMED_OUTPUT_CH1;
			// Quasi pins pull low only for a zero latch bit [R10] [R11]
			PIN32_OUT <= 1'b0;
			PIN33_OUT <= 1'b0;
			PIN33_OE <= ~io_config_2[B_C2DIR_EN] & ~port_two[B_P2_B6];
			if (takeover_mode) begin
				// Active low request and grant, request pin an input [R09]
				PIN30_OUT <= ~bus_req;
				PIN30_OE <= 1'b1;
				PIN31_OUT <= ~grant;
				PIN31_OE <= 1'b1;
				PIN32_OE <= 1'b0;
			end else begin
				// Port 1 bits 5 to 7 [R09] [R10]
				PIN30_OUT <= 1'b0;
				PIN30_OE <= ~port_one[B_P1_LO];
				PIN31_OUT <= 1'b0;
				PIN31_OE <= ~port_one[B_P1_LO + 1];
				PIN32_OE <= ~port_one[B_P1_LO + 2];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SRST);

	// Takeover handshake: request after grant, held, grant after release
	bus_req_grant_a: assert property (bus_req |-> $past(grant)) else $error("request before grant"); // [R13]
	bus_req_hold_a: assert property (bus_req && hold_req |=> bus_req) else $error("request dropped"); // [R14]
	bus_req_pend_a: assert property (grant && hold_req && MEM_CYCLE_PENDING |=> bus_req) // [R12]
		else $error("bus request missed pending cycle");
	grant_release_a: assert property ($rose(grant) |-> $past(BUS_RELEASE) && $past(BUS_IDLE)) // [R15]
		else $error("grant before bus release");
	grant_pin_a: assert property (takeover_mode && $past(takeover_mode) |-> // [R09]
		PIN31_OE && PIN31_OUT == !$past(grant)) else $error("grant pin wrong");
	no_takeover_a: assert property (!takeover_mode |=> !grant) else $error("grant outside takeover"); // [R09]
	// Counter 2 controls and channel routing
	ext_clock_a: assert property (##1 COUNTER2_EXT_CLOCK_EN == // [R02]
		($past(io_config_0[B_C2CLK_EN]) && !$past(io_config_3[B_C2CLK_INH]))) else $error("ext clock gating wrong");
	dir_gate_a: assert property (!io_config_2[B_C2DIR_EN] |=> !COUNTER2_DOWN) // [R18]
		else $error("count down while direction off");
	tout4_drive_a: assert property (io_config_1[B_TOUT4_EN] |=> // [R03]
		PIN26_OE && PIN26_OUT == $past(TIMED_OUTPUT_CH4)) else $error("pin 26 timed output wrong");
	fei1_en_a: assert property (##1 FAST_EVENT_INPUT_EN1 == $past(io_config_0[B_FEI1_EN])) // [R01]
		else $error("event channel 1 enable wrong");

	// Main scenarios
	grant_seen_c: cover property ($rose(grant));
	bus_req_seen_c: cover property ($rose(bus_req) ##[1:100] $fell(grant));
	count_down_c: cover property ($rose(COUNTER2_DOWN));

endmodule // pin_function_select
`default_nettype wire

// File: sim/takeover_master.sv
// Model of an outside master that borrows the external bus
`timescale 1ns/1ps
`default_nettype none
module takeover_master (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bench control
	input wire logic go,
	input wire logic [7:0] hold_len,
	// Handshake pins, active low, and an active high bus ownership flag
	input wire logic grant_n,
	output logic req_n,
	output logic owns_bus
);
	logic [7:0] cnt; // Cycles spent on the bus

	// Request, use the bus under grant, then let go
	always_ff @(posedge clk) begin
		if (srst) begin
			req_n <= 1'b1;
			owns_bus <= 1'b0;
			cnt <= 8'h00;
		end else if (go) begin
			req_n <= 1'b0;
			cnt <= 8'h00;
		end else if (!req_n && !grant_n) begin
			owns_bus <= 1'b1; // Drives the bus only once granted
			cnt <= cnt + 8'h01;
			if (cnt == hold_len) begin
				req_n <= 1'b1; // Request kept until bus use ends
				owns_bus <= 1'b0;
			end
		end
	end
endmodule // takeover_master
`default_nettype wire

// File: sim/pin_function_select_tb.sv
// Self-checking bench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module pin_function_select_tb;
	import pinsel_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic CLK_SYS, SRST, PSEL, PENABLE, PWRITE;
	logic [PADDR_W-1:0] PADDR;
	logic [PDATA_W-1:0] PWDATA, PRDATA;
	logic PREADY, PSLVERR;
	logic PIN26_OUT, PIN26_OE, PIN27_OUT, PIN27_OE, PIN28_OUT, PIN29_OUT;
	logic PIN30_OUT, PIN30_OE, PIN31_OUT, PIN31_OE, PIN32_OUT, PIN32_OE, PIN33_OUT, PIN33_OE;
	logic TO0, TO1, TO4, TO5; // Timed output unit levels
	logic FE1, FE2, FE3, EN1, EN2, EN3; // Event input side
	logic C2CLK, C2EN, C2DOWN; // Counter 2 side
	logic mem_pend, bus_idle, bus_rel; // Bus controller side
	logic p25_lvl, p33_lvl; // Levels driven on input pins
	logic go, req_n, owns; // Outside master
	logic [31:0] rdata; // Last read data
	logic slverr; // Last error response
	int errors, checked, i;
	// Pin levels: driven, else pulled high; undriven pin 32 follows req_n, pin 33 follows p33_lvl
	wire logic pin26_w = PIN26_OE ? PIN26_OUT : 1'b1;
	wire logic pin27_w = PIN27_OE ? PIN27_OUT : 1'b1;
	wire logic pin30_w = PIN30_OE ? PIN30_OUT : 1'b1;
	wire logic pin31_w = PIN31_OE ? PIN31_OUT : 1'b1;
	wire logic pin32_w = PIN32_OE ? PIN32_OUT : req_n;
	wire logic pin33_w = (PIN33_OE && !PIN33_OUT) ? 1'b0 : p33_lvl;

	pin_function_select uut (.CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .PIN25_IN(p25_lvl), .PIN26_IN(pin26_w), .PIN26_OUT(PIN26_OUT),
		.PIN26_OE(PIN26_OE), .PIN27_IN(pin27_w), .PIN27_OUT(PIN27_OUT), .PIN27_OE(PIN27_OE),
		.PIN28_OUT(PIN28_OUT), .PIN29_OUT(PIN29_OUT), .PIN30_IN(pin30_w), .PIN30_OUT(PIN30_OUT),
		.PIN30_OE(PIN30_OE), .PIN31_IN(pin31_w), .PIN31_OUT(PIN31_OUT), .PIN31_OE(PIN31_OE),
		.PIN32_IN(pin32_w), .PIN32_OUT(PIN32_OUT), .PIN32_OE(PIN32_OE), .PIN33_IN(pin33_w),
		.PIN33_OUT(PIN33_OUT), .PIN33_OE(PIN33_OE), .TIMED_OUTPUT_CH0(TO0),
		.TIMED_OUTPUT_CH1(TO1), .TIMED_OUTPUT_CH4(TO4), .TIMED_OUTPUT_CH5(TO5),
		.FAST_EVENT_INPUT_CH1(FE1), .FAST_EVENT_INPUT_CH2(FE2), .FAST_EVENT_INPUT_CH3(FE3),
		.FAST_EVENT_INPUT_EN1(EN1), .FAST_EVENT_INPUT_EN2(EN2), .FAST_EVENT_INPUT_EN3(EN3),
		.COUNTER2_EXT_CLOCK(C2CLK), .COUNTER2_EXT_CLOCK_EN(C2EN), .COUNTER2_DOWN(C2DOWN),
		.MEM_CYCLE_PENDING(mem_pend), .BUS_IDLE(bus_idle), .BUS_RELEASE(bus_rel));

	takeover_master far (.clk(CLK_SYS), .srst(SRST), .go(go), .hold_len(8'h1E),
		.grant_n(pin31_w), .req_n(req_n), .owns_bus(owns));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Wait whole cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask

	// One APB transfer, waits on pready
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= {idx[5:0], 2'b00};
		PWDATA <= {24'h000000, wd};
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		// Only the watchdog ends a wait for ready
		do begin
			@(posedge CLK_SYS);
		end while (PREADY !== 1'b1);
		rdata = PRDATA;
		slverr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// Verdict and end of run
	task automatic tally_and_finish;
		if (errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		CLK_SYS = 1'b0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end

	// Cuts a hang short
	initial begin
		cyc(5000);
		errors++;
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{PSEL, PENABLE, PWRITE, TO0, TO1, TO4, TO5, mem_pend, bus_idle, go, p25_lvl} = '0;
		PADDR = '0;
		PWDATA = '0;
		SRST = 1'b1;
		p33_lvl = 1'b1;
		errors = 0;
		checked = 0;
		cyc(2);
		SRST <= 1'b0;
		// Reset state and an unmapped place
		apb(1'b0, IDX_WSEL, 8'h00);
		chk(rdata, 32'h00000000);
		chk(PREADY, 1'b1);
		apb(1'b0, IDX_PORT1, 8'h00);
		chk(rdata, 32'h000000FF);
		apb(1'b1, 8'h3F, 8'h5A);
		chk(slverr, 1'b1);
		// Event inputs on pins 25 to 27
		apb(1'b1, IDX_CFG0, 8'h54);
		p25_lvl <= 1'b1;
		cyc(5);
		chk({EN3, EN2, EN1}, 3'h7);
		chk(FE1, 1'b1);
		apb(1'b1, IDX_CFG1, 8'h50);
		TO4 <= 1'b1;
		cyc(6);
		chk({PIN26_OE, PIN26_OUT}, 2'h3);
		chk({PIN27_OE, PIN27_OUT}, 2'h2);
		chk({FE3, FE2}, 2'h1);
		TO4 <= 1'b0;
		TO5 <= 1'b1;
		cyc(6);
		chk({FE3, FE2}, 2'h2);
		// Counter 2 clock source
		apb(1'b1, IDX_CFG0, 8'hD0);
		cyc(3);
		chk({C2EN, EN1}, 2'h2);
		chk(C2CLK, 1'b1);
		p25_lvl <= 1'b0;
		apb(1'b1, IDX_CFG3, 8'h01);
		cyc(5);
		chk({C2EN, C2CLK}, 2'h0);
		// Dedicated outputs, every pattern
		for (i = 0; i < 4; i++) begin
			TO0 <= i[0];
			TO1 <= i[1];
			cyc(3);
			chk({PIN29_OUT, PIN28_OUT}, i[1:0]);
		end
		// Port 1 quasi bits
		apb(1'b1, IDX_PORT1, 8'h1F);
		cyc(4);
		chk({PIN32_OE, PIN31_OE, PIN30_OE, PIN32_OUT, PIN31_OUT, PIN30_OUT}, 6'h38);
		apb(1'b0, IDX_PORT1, 8'h00);
		chk(rdata, 32'h0000001F);
		apb(1'b1, IDX_PORT1, 8'hFF);
		// Port 2 bit 6 and direction input
		apb(1'b1, IDX_PORT2, 8'hBF);
		cyc(4);
		chk({PIN33_OE, PIN33_OUT, C2DOWN}, 3'h4);
		apb(1'b0, IDX_PORT2, 8'h00);
		chk(rdata, 32'h000000BF);
		apb(1'b1, IDX_PORT2, 8'hFF);
		cyc(4);
		chk(C2DOWN, 1'b0);
		apb(1'b1, IDX_CFG2, 8'h02);
		cyc(5);
		chk({PIN33_OE, C2DOWN}, 2'h1);
		p33_lvl <= 1'b0;
		cyc(5);
		chk(C2DOWN, 1'b0);
		// Takeover, bus busy and a cycle pending
		apb(1'b1, IDX_WSEL, 8'h80);
		mem_pend <= 1'b1;
		cyc(4);
		chk({PIN32_OE, PIN31_OE, PIN30_OE, PIN31_OUT, PIN30_OUT}, 5'h0F);
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		for (i = 0; i < 8; i++) begin
			cyc(1);
			chk({PIN31_OUT, PIN30_OUT}, 2'h3);
		end
		chk(bus_rel, 1'b1);
		bus_idle <= 1'b1;
		for (i = 0; i < 20 && PIN31_OUT !== 1'b0; i++) cyc(1);
		chk({PIN31_OUT, PIN30_OUT}, 2'h1);
		cyc(3);
		chk({PIN30_OUT, owns}, 2'h1);
		mem_pend <= 1'b0;
		cyc(5);
		chk({PIN31_OUT, PIN30_OUT}, 2'h0);
		// Status while granted: release, request seen, bus request, grant
		apb(1'b0, IDX_STAT, 8'h00);
		chk(rdata, 32'h0000000F);
		for (i = 0; i < 60 && PIN31_OUT !== 1'b1; i++) cyc(1);
		chk({PIN31_OUT, PIN30_OUT, bus_rel}, 3'h6);
		// Second takeover, nothing pending
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		for (i = 0; i < 20 && PIN31_OUT !== 1'b0; i++) cyc(1);
		cyc(4);
		chk({PIN31_OUT, PIN30_OUT}, 2'h1);
		for (i = 0; i < 60 && PIN31_OUT !== 1'b1; i++) cyc(1);
		apb(1'b1, IDX_WSEL, 8'h00);
		cyc(4);
		chk({PIN31_OE, PIN30_OE}, 2'h0);
		tally_and_finish;
	end
endmodule // pin_function_select_tb
`default_nettype wire
